// ---- hdl/dmia_data_memory.v ----
// data memory space with special register area, general purpose ram and
// three indirect access ports with their memory pointers.
// assumes the processor core issues at most one access per clock, on the
// same clock, and that other special registers live outside this block.
// assumes the outside registers answer a read in the same cycle: bit
// operations on them are read-modify-write through that one read path.
`include "dmia_regs.vh"
`default_nettype none

// Contract
// - general purpose ram is readable and writable
// - bit set/clear changes only addressed bit
// - protected special registers ignore program writes
// - unused special locations read as 00H
// - indirect port access redirects through its pointer
// - first indirect port reaches sector 0 only
// - second and third ports reach any sector
// - port hit through pointer reads 00H, no write
// - specials at 00H-7FH, ram at 80H-FFH
// - specials in every sector, eeprom control sector 1
// - high pointer selects sector, low selects byte
// - pointers are ordinary read/write storage
module dmia_data_memory #(
    parameter NUM_SECTORS = `DMIA_NUM_SECTORS,
    parameter GP_SECTORS = `DMIA_GP_SECTORS,
    parameter GP_DEPTH = `DMIA_GP_DEPTH,
    parameter [127:0] SFR_USED = `DMIA_SFR_USED_MASK,
    parameter [127:0] SFR_PROT = `DMIA_SFR_PROT_MASK
) (
    input wire I_REF_CLK,
    input wire I_RST,
    input wire [7:0] i_sector,
    input wire [7:0] i_offset,
    input wire i_rd,
    input wire i_wr,
    input wire i_bit_set,
    input wire i_bit_clr,
    input wire [2:0] i_bit_sel,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    output reg o_rvalid,
    output wire [7:0] o_sfr_sector,
    output wire [6:0] o_sfr_offset,
    output wire o_sfr_sel,
    output wire o_sfr_we,
    output wire [7:0] o_sfr_wdata,
    input wire [7:0] i_sfr_rdata
);

    // apply a single bit operation to a byte, other bits kept
    // the shift is by a 3-bit index, so no bit outside the byte is touched
    function [7:0] dmia_bit_op;
        input [7:0] val;
        input [2:0] pos;
        input set;
        reg [7:0] one_hot;
        begin
            one_hot = 8'h01 << pos;
            if (set) begin
                dmia_bit_op = val | one_hot;
            end else begin
                dmia_bit_op = val & ~one_hot;
            end
        end
    endfunction

    // true when a sector number names an existing sector
    // sectors beyond the last read as 00 and drop writes, they never wrap
    function sector_ok;
        input [7:0] sec;
        begin
            sector_ok = ({24'h000000, sec} < NUM_SECTORS);
        end
    endfunction

    // true when an offset is one of the indirect access ports
    // a pointer that lands on one of them reads 00 and writes nothing
    function is_port;
        input [7:0] ofs;
        begin
            is_port = (ofs == `DMIA_OFS_IND_PORT_ZERO) ||
                      (ofs == `DMIA_OFS_IND_PORT_ONE) ||
                      (ofs == `DMIA_OFS_IND_PORT_TWO);
        end
    endfunction

    // true when an offset is one of the five memory pointers; they live
    // here and are never routed to the outside registers
    function is_pointer;
        input [7:0] ofs;
        begin
            is_pointer = (ofs == `DMIA_OFS_PTR_ZERO) ||
                         (ofs == `DMIA_OFS_PTR_ONE_LOW) ||
                         (ofs == `DMIA_OFS_PTR_ONE_HIGH) ||
                         (ofs == `DMIA_OFS_PTR_TWO_LOW) ||
                         (ofs == `DMIA_OFS_PTR_TWO_HIGH);
        end
    endfunction

    // true when an outside register sits at this special offset of this
    // sector; the eeprom control slot is the one sector-specific entry
    function sfr_present;
        input [7:0] sec;
        input [7:0] ofs;
        begin
            if (ofs == `DMIA_OFS_EEPROM_CTRL) begin
                sfr_present = (sec == `DMIA_EEPROM_SECTOR);
            end else begin
                sfr_present = SFR_USED[ofs[6:0]];
            end
        end
    endfunction

    // pointer storage
    // the five pointers are plain registers of the special area
    reg [7:0] ptr_zero_r;
    reg [7:0] ptr_one_low_r;
    reg [7:0] ptr_one_high_r;
    reg [7:0] ptr_two_low_r;
    reg [7:0] ptr_two_high_r;
    reg [7:0] ptr_zero_nxt;
    reg [7:0] ptr_one_low_nxt;
    reg [7:0] ptr_one_high_nxt;
    reg [7:0] ptr_two_low_nxt;
    reg [7:0] ptr_two_high_nxt;

    // general purpose ram, not reset (contents are undefined after power up)
    reg [7:0] gp_mem_r [0:GP_DEPTH-1];

    // resolved location of the current request and what it lands on
    reg [7:0] eff_sec;
    reg [7:0] eff_ofs;
    reg eff_sec_ok;
    reg hit_port;
    reg hit_gp;
    reg hit_ext;
    reg [7:0] rd_val;
    reg [7:0] wr_val;
    wire any_wr;
    wire gp_bank_ok;
    wire [6:0] gp_idx;
    wire hit_ptr;
    wire ptr_wr_en;
    wire sfr_locked;
    reg [7:0] rdata_nxt;

    // any request that stores something, a whole byte or a single bit
    assign any_wr = i_wr | i_bit_set | i_bit_clr;

    // resolve the addressed location; ports redirect through their pointer
    // the first port is pinned to sector 0 and uses its 8-bit pointer whole
    always @* begin
        eff_sec = i_sector;
        eff_ofs = i_offset;
        if (i_offset == `DMIA_OFS_IND_PORT_ZERO) begin
            eff_sec = `DMIA_SECTOR_ZERO;
            eff_ofs = ptr_zero_r;
        end else if (i_offset == `DMIA_OFS_IND_PORT_ONE) begin
            eff_sec = ptr_one_high_r;
            eff_ofs = ptr_one_low_r;
        end else if (i_offset == `DMIA_OFS_IND_PORT_TWO) begin
            eff_sec = ptr_two_high_r;
            eff_ofs = ptr_two_low_r;
        end
    end

    // only one level of redirection: a pointer aimed at a port lands nowhere
    // a second hop would need a second lookup in the same cycle
    always @* begin
        eff_sec_ok = sector_ok(eff_sec);
        hit_port = is_port(eff_ofs);
        hit_gp = 1'b0;
        hit_ext = 1'b0;
        if (eff_sec_ok && !hit_port) begin
            if (eff_ofs >= `DMIA_GP_BASE) begin
                hit_gp = gp_bank_ok;
            end else if (!is_pointer(eff_ofs)) begin
                hit_ext = sfr_present(eff_sec, eff_ofs);
            end
        end
    end

    // general purpose ram exists in the low sectors only
    assign gp_bank_ok = ({24'h000000, eff_sec} < GP_SECTORS);
    assign gp_idx = eff_ofs[6:0];

    // pointers answer wherever the resolved location names them, in any
    // existing sector, since they are mirrored like the other specials
    assign hit_ptr = eff_sec_ok & ~hit_port & is_pointer(eff_ofs);
    assign ptr_wr_en = any_wr & hit_ptr;

    // read mux; pointers appear the same in every sector
    // anything unclaimed falls through to the unused value
    always @* begin
        rd_val = `DMIA_UNUSED_DATA;
        if (eff_sec_ok && !hit_port) begin
            if (hit_gp) begin
                rd_val = gp_mem_r[gp_idx];
            end else if (hit_ext) begin
                rd_val = i_sfr_rdata;
            end else begin
                case (eff_ofs)
                    `DMIA_OFS_PTR_ZERO: rd_val = ptr_zero_r;
                    `DMIA_OFS_PTR_ONE_LOW: rd_val = ptr_one_low_r;
                    `DMIA_OFS_PTR_ONE_HIGH: rd_val = ptr_one_high_r;
                    `DMIA_OFS_PTR_TWO_LOW: rd_val = ptr_two_low_r;
                    `DMIA_OFS_PTR_TWO_HIGH: rd_val = ptr_two_high_r;
                    default: rd_val = `DMIA_UNUSED_DATA;
                endcase
            end
        end
    end

    // value to store: full byte write wins over bit operations
    // and a set wins over a clear when both arrive together
    always @* begin
        if (i_wr) begin
            wr_val = i_wdata;
        end else begin
            wr_val = dmia_bit_op(rd_val, i_bit_sel, i_bit_set);
        end
    end

    // outside special registers see the write in the same cycle, so a read
    // in the next cycle already returns the new value
    assign o_sfr_sel = hit_ext;
    assign o_sfr_sector = eff_sec;
    assign o_sfr_offset = eff_ofs[6:0];
    assign o_sfr_wdata = wr_val;
    assign o_sfr_we = any_wr & hit_ext & ~sfr_locked;

    // protected registers: the strobe is held back here, so the outside
    // logic never needs to know which of its registers are read only
    assign sfr_locked = SFR_PROT[eff_ofs[6:0]];

    // general purpose ram write port
    // no reset on the ram keeps it cheap; software must load it first
    always @(posedge I_REF_CLK) begin
        if (any_wr && hit_gp) begin
            gp_mem_r[gp_idx] <= wr_val;
        end
    end

    // pointer next values; a write through another port lands here too,
    // which is how the core steps a pointer by indirect means
    always @* begin
        ptr_zero_nxt = ptr_zero_r;
        ptr_one_low_nxt = ptr_one_low_r;
        ptr_one_high_nxt = ptr_one_high_r;
        ptr_two_low_nxt = ptr_two_low_r;
        ptr_two_high_nxt = ptr_two_high_r;
        if (ptr_wr_en) begin
            case (eff_ofs)
                `DMIA_OFS_PTR_ZERO: ptr_zero_nxt = wr_val;
                `DMIA_OFS_PTR_ONE_LOW: ptr_one_low_nxt = wr_val;
                `DMIA_OFS_PTR_ONE_HIGH: ptr_one_high_nxt = wr_val;
                `DMIA_OFS_PTR_TWO_LOW: ptr_two_low_nxt = wr_val;
                `DMIA_OFS_PTR_TWO_HIGH: ptr_two_high_nxt = wr_val;
                default: ptr_zero_nxt = ptr_zero_r;   // filtered out by is_pointer
            endcase
        end
    end

    // pointer registers; reset to a known value because software may use a
    // pointer before loading it, and an unknown sector would be worse than 00
    always @(posedge I_REF_CLK) begin
        if (I_RST) begin
            ptr_zero_r <= `DMIA_PTR_RESET;
            ptr_one_low_r <= `DMIA_PTR_RESET;
            ptr_one_high_r <= `DMIA_PTR_RESET;
            ptr_two_low_r <= `DMIA_PTR_RESET;
            ptr_two_high_r <= `DMIA_PTR_RESET;
        end else begin
            ptr_zero_r <= ptr_zero_nxt;
            ptr_one_low_r <= ptr_one_low_nxt;
            ptr_one_high_r <= ptr_one_high_nxt;
            ptr_two_low_r <= ptr_two_low_nxt;
            ptr_two_high_r <= ptr_two_high_nxt;
        end
    end

    // read data next value: only a taken read moves it, so o_rdata holds
    // between reads and a slow core may pick it up later
    always @* begin
        if (i_rd) begin
            rdata_nxt = rd_val;
        end else begin
            rdata_nxt = o_rdata;
        end
    end

    // read data registered, valid for one cycle after the request
    always @(posedge I_REF_CLK) begin
        if (I_RST) begin
            o_rdata <= `DMIA_UNUSED_DATA;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd;
            o_rdata <= rdata_nxt;
        end
    end

endmodule // dmia_data_memory

`default_nettype wire

// ---- hdl/dmia_regs.vh ----
// constants for the data memory and indirect addressing block
// assumes a byte wide data memory with 7-bit special register offsets
`ifndef DMIA_REGS_VH
`define DMIA_REGS_VH

// indirect access ports and memory pointers (special register offsets)
`define DMIA_OFS_IND_PORT_ZERO 8'h00
`define DMIA_OFS_PTR_ZERO 8'h01
`define DMIA_OFS_IND_PORT_ONE 8'h02
`define DMIA_OFS_PTR_ONE_LOW 8'h03
`define DMIA_OFS_PTR_ONE_HIGH 8'h04
`define DMIA_OFS_IND_PORT_TWO 8'h0C
`define DMIA_OFS_PTR_TWO_LOW 8'h0D
`define DMIA_OFS_PTR_TWO_HIGH 8'h0E

// eeprom control register, present in one sector only
`define DMIA_OFS_EEPROM_CTRL 8'h40
`define DMIA_EEPROM_SECTOR 8'h01

// area split: special registers below, general purpose ram from here up
`define DMIA_GP_BASE 8'h80
`define DMIA_GP_DEPTH 128

// sector geometry
`define DMIA_NUM_SECTORS 2
`define DMIA_GP_SECTORS 1
`define DMIA_SECTOR_ZERO 8'h00

// value read from unused locations and from a port reached through a pointer
`define DMIA_UNUSED_DATA 8'h00
// pointer reset value
`define DMIA_PTR_RESET 8'h00

// special register occupancy, one bit per offset 00H..7FH
`define DMIA_SFR_USED_MASK 128'h0000_0000_0000_1FFF_FF0F_F07F_FFFF_F7FF
// protected (read only) special registers, one bit per offset
`define DMIA_SFR_PROT_MASK 128'h0000_0000_0000_0000_0000_0000_0000_0000

`endif

// ---- verification/dmia_sfr_model.sv ----
// outside special registers answering in the same cycle
// assumes the block's resolved sector, offset and write strobe
`default_nettype none
module dmia_sfr_model (
    input wire logic clk,
    input wire logic sel,
    input wire logic we,
    input wire logic [7:0] sector,
    input wire logic [6:0] offset,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:127];
    logic [7:0] last_r = 8'h00;
    wire hit;
    // the eeprom control slot answers in sector 1 only; elsewhere it shows the inverted last value
    assign hit = sel && !(offset == 7'h40 && sector != 8'h01);
    // specials are mirrored in every sector, so the sector picks no row
    // unselected bus shows the inverted last value, so stale data never matches
    assign rdata = hit ? mem[offset] : ~last_r;
    // cleared at start so a dropped write reads back as a known 00
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'h00;
        end
    end
    always @(posedge clk) begin
        last_r <= rdata;
        if (we && hit) begin
            mem[offset] <= wdata;
        end
    end
endmodule // dmia_sfr_model
`default_nettype wire

// ---- verification/dmia_monitor.sv ----
// port checker for the data memory block
// assumes one clock and a synchronous active high reset
`default_nettype none
module dmia_mon (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic [7:0] i_sector,
    input wire logic [7:0] i_offset,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_sfr_sel,
    input wire logic [7:0] o_sfr_sector,
    input wire logic [6:0] o_sfr_offset,
    input wire logic o_sfr_we,
    input wire logic [7:0] o_sfr_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    // direct hit on special register 10H of sector 0
    wire s10 = i_sector == 8'h00 && i_offset == 8'h10;
    sequence s_answer;
        ##1 o_rvalid;
    endsequence
    chk_read_answer:
        assert property (i_rd |-> s_answer) else $error("read unanswered");
    chk_no_answer:
        assert property (!i_rd |=> !o_rvalid) else $error("stray valid");
    chk_data_hold:
        assert property (!i_rd |=> $stable(o_rdata)) else $error("data moved");
    chk_ram_local:
        assert property (i_offset[7] |-> !o_sfr_sel) else $error("ram routed out");
    chk_sfr_route:
        assert property (s10 |-> o_sfr_sel && o_sfr_offset == 7'h10 && o_sfr_sector == 8'h00)
        else $error("bad route");
    chk_sfr_write:
        assert property (s10 && i_wr |-> o_sfr_we && o_sfr_wdata == i_wdata)
        else $error("bad write");
    chk_unused_zero:
        assert property (i_rd && !i_sector[0] && i_offset == 8'h0B |=> o_rdata == 8'h00)
        else $error("unused not zero");
    chk_eeprom_hidden:
        assert property (i_sector == 8'h00 && i_offset == 8'h40 |-> !o_sfr_sel)
        else $error("eeprom in sector 0");
    chk_prot_write:
        assert property (o_sfr_sel && o_sfr_offset == 7'h11 |-> !o_sfr_we)
        else $error("protected register written");
endmodule // dmia_mon
bind dmia_data_memory dmia_mon mon_i (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST),
    .i_sector(i_sector), .i_offset(i_offset), .i_rd(i_rd), .i_wr(i_wr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_sfr_sel(o_sfr_sel),
    .o_sfr_sector(o_sfr_sector), .o_sfr_offset(o_sfr_offset), .o_sfr_we(o_sfr_we),
    .o_sfr_wdata(o_sfr_wdata));
`default_nettype wire

// ---- verification/tb_data_memory_indirect_addressing.sv ----
// self-checking bench for the data memory block
// assumes the outside register model answers in the same cycle
`default_nettype none
module tb_data_memory_indirect_addressing;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, rd = 0, wr = 0, bs = 0, bc = 0, sel, we, rv;
    logic [7:0] sec = 0, ofs = 0, wd = 0, rdat, srd, ssec, swd, d, a;
    logic [6:0] sofs;
    logic [2:0] bsel = 0;
    logic [31:0] seed = 32'd14;
    int bad_count = 0, compares = 0;
    // offset 11H is made read only here so that the protection path is exercised
    dmia_data_memory #(.SFR_PROT(128'h0000_0000_0000_0000_0000_0000_0002_0000))
        dmia_data_memory_i (.I_REF_CLK(clk), .I_RST(rst), .i_sector(sec),
        .i_offset(ofs), .i_rd(rd), .i_wr(wr), .i_bit_set(bs), .i_bit_clr(bc),
        .i_bit_sel(bsel), .i_wdata(wd), .o_rdata(rdat), .o_rvalid(rv), .o_sfr_sector(ssec),
        .o_sfr_offset(sofs), .o_sfr_sel(sel), .o_sfr_we(we), .o_sfr_wdata(swd),
        .i_sfr_rdata(srd));
    dmia_sfr_model dmia_sfr_model_i (.clk(clk), .sel(sel), .we(we), .sector(ssec),
        .offset(sofs), .wdata(swd), .rdata(srd));
    initial begin
        forever #10 clk = ~clk;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // expected byte after one bit set or clear
    function automatic logic [7:0] bop(logic [7:0] v, logic [2:0] b, logic s);
        return s ? v | (8'h01 << b) : v & ~(8'h01 << b);
    endfunction
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request for a single cycle; k is {rd, wr, set, clr}, bit index from v
    task automatic acc(logic [7:0] s, logic [7:0] o, logic [3:0] k, logic [7:0] v);
        @(posedge clk);
        sec <= s;
        ofs <= o;
        {rd, wr, bs, bc} <= k;
        wd <= v;
        bsel <= v[2:0];
        @(posedge clk);
        {rd, wr, bs, bc} <= 4'h0;
        #1;
    endtask
    task automatic rchk(logic [7:0] s, logic [7:0] o, logic [7:0] exp);
        acc(s, o, 4'h8, 8'h00);
        chk({7'h00, rv}, 8'h01);
        chk(rdat, exp);
    endtask
    task automatic test_done();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog far beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h00, 8'h01, 8'h00);
        for (int n = 0; n < 8; n++) begin
            a = 8'h80 | rnd();
            d = rnd();
            acc(8'h00, a, 4'h4, d);
            rchk(8'h00, a, d);
            acc(8'h00, a, 4'h2, d);
            rchk(8'h00, a, bop(d, d[2:0], 1'b1));
            acc(8'h00, a, 4'h1, ~d);
            rchk(8'h00, a, bop(bop(d, d[2:0], 1'b1), ~d[2:0], 1'b0));
        end
        d = rnd();
        acc(8'h00, 8'h10, 4'h4, d);
        rchk(8'h00, 8'h10, d);
        rchk(8'h01, 8'h10, d);
        // protected register: byte write and bit set are both dropped
        acc(8'h00, 8'h11, 4'h4, d | 8'h01);
        rchk(8'h00, 8'h11, 8'h00);
        acc(8'h01, 8'h11, 4'h2, 8'h03);
        rchk(8'h01, 8'h11, 8'h00);
        rchk(8'h00, 8'h0B, 8'h00);
        rchk(8'h00, 8'h40, 8'h00);
        acc(8'h01, 8'h40, 4'h4, 8'h5A);
        rchk(8'h01, 8'h40, 8'h5A);
        // first port through pointer zero, written with a stray sector
        acc(8'h00, 8'h85, 4'h4, 8'hC3);
        acc(8'h00, 8'h01, 4'h4, 8'h85);
        rchk(8'h00, 8'h01, 8'h85);
        rchk(8'h00, 8'h00, 8'hC3);
        acc(8'h01, 8'h00, 4'h4, 8'h3C);
        rchk(8'h00, 8'h85, 8'h3C);
        rchk(8'h01, 8'h85, 8'h00);
        // the other two ports reach sector 1
        acc(8'h00, 8'h04, 4'h4, 8'h01);
        acc(8'h00, 8'h03, 4'h4, 8'h40);
        rchk(8'h00, 8'h02, 8'h5A);
        acc(8'h00, 8'h0E, 4'h4, 8'h01);
        acc(8'h00, 8'h0D, 4'h4, 8'h40);
        rchk(8'h00, 8'h0C, 8'h5A);
        // pointer aimed at its own port: reads zero, writes dropped
        acc(8'h00, 8'h01, 4'h4, 8'h00);
        acc(8'h00, 8'h00, 4'h4, 8'hFF);
        rchk(8'h00, 8'h00, 8'h00);
        // reset in mid-run: pointers return to 00, the ram keeps its data
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h00, 8'h04, 8'h00);
        rchk(8'h00, 8'h85, 8'h3C);
        test_done();
    end
endmodule // tb_data_memory_indirect_addressing
`default_nettype wire
